/* ecm_ctrl.sv */
// Module: host controller that sequences writes, reads and scrubs of the ECC chip
// Behaviour
// - Syndrome output enable held low always
// - Write: data latch high, others low
// - Read: both input latches high, mode 4
// - Any-error low means no further action
// - Data scrub: latch, buffers on, rewrite
// - Check scrub: data latch low, regenerate
// - Wait on each read until flags settle
// - Latch enables may be tied together
// - Double error needs other recovery
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module ecm_ctrl (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // Software port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [31:0]      rdata,
   // Device control pins
   output logic             data_in_latch_enable,
   output logic             check_syndrome_latch_enable,
   output logic             output_latch_enable_n,
   output logic             syndrome_output_enable_n,
   output logic             data_buffer_enable_lo_n,
   output logic             data_buffer_enable_hi_n,
   output logic             mode_rw_bit,
   output logic             mode_select_bit1,
   output logic             mode_select_bit0,
   // Device flags
   input  wire logic        any_error_flag,
   input  wire logic        error_class_flag_low,
   input  wire logic        error_class_flag_high,
   // Data port, two-way
   input  wire logic [15:0] data_port_pins_in,
   output logic [15:0]      data_port_pins_out,
   output logic [15:0]      data_port_pins_oe,
   // Memory strobes
   output logic             mem_read_en,
   output logic             mem_write_en,
   // Processor wait
   output logic             proc_wait
);
   // ****************************************
   // Flag synchroniser
   // ****************************************
   ecm_flag_if flg ();
   ecm_flag_sync u_sync (
      .core_clk              (core_clk),
      .rstn                  (rstn),
      .any_error_flag        (any_error_flag),
      .error_class_flag_low  (error_class_flag_low),
      .error_class_flag_high (error_class_flag_high),
      .flags                 (flg)
   );

   // ****************************************
   // State and registers
   // ****************************************
   ecm_pkg::ecm_state_e state_r, state_nxt;
   logic [3:0]          cnt_r, cnt_nxt;
   logic [15:0]         wdata_r;
   logic [15:0]         rdata_r;
   logic                scrub_en_r;
   ecm_pkg::ecm_err_e   last_err_r;
   logic [15:0]         errcnt_r;
   logic [31:0]         rd_word_r;
   logic [15:0]         din_meta_r;
   logic [15:0]         din_sync_r;

   wire sel_ctrl   = (addr == ecm_pkg::REG_CTRL);
   wire sel_wdata  = (addr == ecm_pkg::REG_WDATA);
   wire idle       = (state_r == ecm_pkg::ECM_IDLE);
   wire start_wr   = wr_stb && sel_ctrl && wdata[ecm_pkg::CTRL_START_WR] && idle;
   wire start_rd   = wr_stb && sel_ctrl && wdata[ecm_pkg::CTRL_START_RD] && idle && !start_wr;
   wire cnt_done   = (cnt_r == 4'h0);
   wire need_wb    = scrub_en_r &&
                     ((last_err_r == ecm_pkg::ECM_ERR_DATA) || (last_err_r == ecm_pkg::ECM_ERR_CHECK));

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_done ? 4'h0 : cnt_r - 4'h1;
      case (state_r)
         ecm_pkg::ECM_IDLE: begin
            if (start_wr) begin
               state_nxt = ecm_pkg::ECM_WR_GEN;
               cnt_nxt   = ecm_pkg::CHECK_GEN_CYC;
            end else if (start_rd) begin
               state_nxt = ecm_pkg::ECM_RD_OPEN;
               cnt_nxt   = ecm_pkg::FLAG_WAIT_CYC;
            end
         end
         ecm_pkg::ECM_WR_GEN:   if (cnt_done) state_nxt = ecm_pkg::ECM_WR_PULSE;
         ecm_pkg::ECM_WR_PULSE: state_nxt = ecm_pkg::ECM_IDLE;
         ecm_pkg::ECM_RD_OPEN:  if (cnt_done) state_nxt = ecm_pkg::ECM_RD_LATCH;
         ecm_pkg::ECM_RD_LATCH: begin
            state_nxt = ecm_pkg::ECM_RD_DRIVE;
            cnt_nxt   = ecm_pkg::BUF_WAIT_CYC;
         end
         ecm_pkg::ECM_RD_DRIVE: begin
            if (cnt_done) begin
               state_nxt = need_wb ? ecm_pkg::ECM_WB_GEN : ecm_pkg::ECM_IDLE;
               cnt_nxt   = ecm_pkg::CHECK_GEN_CYC;
            end
         end
         ecm_pkg::ECM_WB_GEN:   if (cnt_done) state_nxt = ecm_pkg::ECM_WB_PULSE;
         ecm_pkg::ECM_WB_PULSE: state_nxt = ecm_pkg::ECM_IDLE;
         default:               state_nxt = ecm_pkg::ECM_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_r <= ecm_pkg::ECM_IDLE;
         cnt_r   <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // ****************************************
   // Data input synchroniser and captures
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         din_meta_r <= 16'h0000;
         din_sync_r <= 16'h0000;
      end else begin
         din_meta_r <= data_port_pins_in;
         din_sync_r <= din_meta_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wdata_r    <= 16'h0000;
         scrub_en_r <= 1'b0;
         last_err_r <= ecm_pkg::ECM_ERR_NONE;
         errcnt_r   <= 16'h0000;
         rdata_r    <= 16'h0000;
      end else begin
         if (wr_stb && sel_wdata && idle)
            wdata_r <= wdata[15:0];
         if (wr_stb && sel_ctrl)
            scrub_en_r <= wdata[ecm_pkg::CTRL_SCRUB_EN];
         // Flags are judged once, when the read settle time has run out
         if (state_r == ecm_pkg::ECM_RD_OPEN && cnt_done) begin
            last_err_r <= flg.err_class;
            if (flg.any_err)
               errcnt_r <= errcnt_r + 16'h0001;
         end
         // Device output latch already holds the corrected word
         if (state_r == ecm_pkg::ECM_RD_DRIVE && cnt_done)
            rdata_r <= din_sync_r;
      end
   end

   // ****************************************
   // Software read port
   // ****************************************
   wire [31:0] status_word = {28'h000_0000, last_err_r, 1'b0, !idle};
   wire [31:0] rd_mux =
      (addr == ecm_pkg::REG_CTRL)   ? {29'h0000_0000, scrub_en_r, 2'b00} :
      (addr == ecm_pkg::REG_WDATA)  ? {16'h0000, wdata_r} :
      (addr == ecm_pkg::REG_RDATA)  ? {16'h0000, rdata_r} :
      (addr == ecm_pkg::REG_STATUS) ? status_word :
      (addr == ecm_pkg::REG_ERRCNT) ? {16'h0000, errcnt_r} : ecm_pkg::RST_WORD;

   always_ff @(posedge core_clk) begin
      if (!rstn)
         rd_word_r <= ecm_pkg::RST_WORD;
      else if (rd_stb)
         rd_word_r <= rd_mux;
   end
   assign rdata = rd_word_r;

   // ****************************************
   // Pin drive
   // ****************************************
   wire st_wr    = (state_r == ecm_pkg::ECM_WR_GEN) || (state_r == ecm_pkg::ECM_WR_PULSE);
   wire st_rd    = (state_r == ecm_pkg::ECM_RD_OPEN);
   wire st_wb    = (state_r == ecm_pkg::ECM_WB_GEN) || (state_r == ecm_pkg::ECM_WB_PULSE);
   wire st_drive = (state_r == ecm_pkg::ECM_RD_DRIVE) || st_wb;
   // A check bit error needs the data latch low so regenerated bits match the data
   wire latch_wb = 1'b0;

   assign syndrome_output_enable_n    = 1'b0;
   assign data_in_latch_enable        = st_wr || st_rd || (st_wb && latch_wb);
   // Check latch opens only in the read state; the data latch also opens in the write states
   assign check_syndrome_latch_enable = st_rd;
   // Output latches close after the read settles and hold through the write-back
   assign output_latch_enable_n       = !(st_wr || st_rd);
   assign data_buffer_enable_lo_n     = !st_drive;
   assign data_buffer_enable_hi_n     = !st_drive;
   // Mode 4 only while reading; rw low releases the check port back to the device
   assign mode_rw_bit      = (st_rd || state_r == ecm_pkg::ECM_RD_LATCH ||
                              state_r == ecm_pkg::ECM_RD_DRIVE) ? ecm_pkg::MODE_NORMAL_READ[2]
                                                                : ecm_pkg::MODE_NORMAL_WRITE[2];
   assign mode_select_bit1 = ecm_pkg::MODE_NORMAL_WRITE[1];
   assign mode_select_bit0 = ecm_pkg::MODE_NORMAL_WRITE[0];
   assign data_port_pins_out = wdata_r;
   assign data_port_pins_oe  = st_wr ? 16'hFFFF : 16'h0000;
   assign mem_read_en  = st_rd;
   assign mem_write_en = (state_r == ecm_pkg::ECM_WR_PULSE) || (state_r == ecm_pkg::ECM_WB_PULSE);
   // Double errors are only reported; software chooses the recovery
   assign proc_wait    = !idle;

   // ****************************************
   // Checks
   // ****************************************
   buf_oe_excl_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !(data_port_pins_oe != 16'h0000 && (!data_buffer_enable_lo_n || !data_buffer_enable_hi_n)))
      else $error("host and device drive data port together");
   synd_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !syndrome_output_enable_n) else $error("syndrome output enable not low");
   rd_mode_a: assert property (@(posedge core_clk) disable iff (!rstn)
      mem_read_en |-> (mode_rw_bit && data_in_latch_enable && check_syndrome_latch_enable))
      else $error("read without mode 4 and open latches");
   wr_mode_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_r == ecm_pkg::ECM_WR_GEN) |-> (!mode_rw_bit && !check_syndrome_latch_enable &&
                                           !output_latch_enable_n)) else $error("write setup wrong");
   wr_settle_a: assert property (@(posedge core_clk) disable iff (!rstn)
      start_wr |=> (!mem_write_en)[*3] ##1 (!mem_write_en) ##1 mem_write_en)
      else $error("write strobe not after check settle");
   rd_wait_a: assert property (@(posedge core_clk) disable iff (!rstn)
      start_rd |=> mem_read_en[*8] ##1 !mem_read_en) else $error("read settle time wrong");
   wb_rw_a: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(mem_write_en) && !data_port_pins_oe[0] |-> (!mode_rw_bit && output_latch_enable_n &&
                                                         !data_buffer_enable_hi_n))
      else $error("write-back without latched output");
   ck_scrub_a: assert property (@(posedge core_clk) disable iff (!rstn)
      st_wb |-> !data_in_latch_enable && !mem_read_en) else $error("check scrub data latch open");
   no_wb_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_r == ecm_pkg::ECM_RD_DRIVE && cnt_done && last_err_r == ecm_pkg::ECM_ERR_NONE)
      |=> idle) else $error("action taken without error");
endmodule : ecm_ctrl

/* ecm_pkg.sv */
// Package: constants, register map and states of the ECC chip controller
package ecm_pkg;

   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int CHECK_GEN_NS  = 30;
   localparam int FLAG_VALID_NS = 50;
   localparam int BUF_EN_NS     = 15;
   localparam int SYNC_STAGES   = 2;
   localparam logic [3:0] CHECK_GEN_CYC =
      4'((CHECK_GEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Flags pass the synchroniser before they are looked at
   localparam logic [3:0] FLAG_WAIT_CYC =
      4'((FLAG_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
   localparam logic [3:0] BUF_WAIT_CYC  =
      4'((BUF_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);

   // ****************************************
   // Widths and modes
   // ****************************************
   localparam int DATA_W = 16;
   localparam logic [2:0] MODE_NORMAL_WRITE = 3'h0;
   localparam logic [2:0] MODE_NORMAL_READ  = 3'h4;

   // ****************************************
   // Software register map
   // ****************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_WDATA  = 8'h04;
   localparam logic [7:0] REG_RDATA  = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_ERRCNT = 8'h10;
   localparam int CTRL_START_WR = 0;
   localparam int CTRL_START_RD = 1;
   localparam int CTRL_SCRUB_EN = 2;
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;

   typedef enum logic [1:0] {
      ECM_ERR_NONE   = 2'b00,
      ECM_ERR_CHECK  = 2'b01,
      ECM_ERR_DATA   = 2'b10,
      ECM_ERR_DOUBLE = 2'b11
   } ecm_err_e;

   typedef enum logic [3:0] {
      ECM_IDLE     = 4'b0000,
      ECM_WR_GEN   = 4'b0001,
      ECM_WR_PULSE = 4'b0010,
      ECM_RD_OPEN  = 4'b0011,
      ECM_RD_LATCH = 4'b0100,
      ECM_RD_DRIVE = 4'b0101,
      ECM_WB_GEN   = 4'b0110,
      ECM_WB_PULSE = 4'b0111
   } ecm_state_e;

endpackage : ecm_pkg

/* ecm_flag_if.sv */
// Interface: synchronised and classified error flags
`timescale 1ns/1ps
interface ecm_flag_if;
   logic                 any_err;
   ecm_pkg::ecm_err_e    err_class;
   modport src (output any_err, output err_class);
   modport dst (input any_err, input err_class);
endinterface : ecm_flag_if

/* ecm_flag_sync.sv */
// Module: synchroniser and classifier for the device error flags
`timescale 1ns/1ps
module ecm_flag_sync (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rstn,
   // Device flags
   input  wire logic any_error_flag,
   input  wire logic error_class_flag_low,
   input  wire logic error_class_flag_high,
   // Result
   ecm_flag_if.src   flags
);
   logic [2:0] meta_r;
   logic [2:0] sync_r;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         meta_r <= 3'h0;
         sync_r <= 3'h0;
      end else begin
         meta_r <= {error_class_flag_high, error_class_flag_low, any_error_flag};
         sync_r <= meta_r;
      end
   end

   // With the flag low nothing more needs doing for the read
   assign flags.any_err   = sync_r[0];
   // High class flag alone marks a check bit, both a data bit, neither a double
   assign flags.err_class = !sync_r[0] ? ecm_pkg::ECM_ERR_NONE   :
                            !sync_r[2] ? ecm_pkg::ECM_ERR_DOUBLE :
                            sync_r[1]  ? ecm_pkg::ECM_ERR_DATA   : ecm_pkg::ECM_ERR_CHECK;
endmodule : ecm_flag_sync

/* ecm_dev_model.sv */
// Behavioural model of the ECC chip together with its one-word memory
`timescale 1ns/1ps
module ecm_dev_model (
   // Memory clock
   input  wire logic        core_clk,
   // Device control pins
   input  wire logic        data_in_latch_enable,
   input  wire logic        check_syndrome_latch_enable,
   input  wire logic        output_latch_enable_n,
   input  wire logic        syndrome_output_enable_n,
   input  wire logic        data_buffer_enable_lo_n,
   input  wire logic        data_buffer_enable_hi_n,
   input  wire logic        mode_rw_bit,
   input  wire logic        mode_select_bit1,
   input  wire logic        mode_select_bit0,
   // Memory strobes and host drive
   input  wire logic        mem_read_en,
   input  wire logic        mem_write_en,
   input  wire logic [15:0] data_port_pins_out,
   input  wire logic [15:0] data_port_pins_oe,
   // Fault injection into the stored word
   input  wire logic        inj,
   input  wire logic [15:0] inj_d,
   input  wire logic [5:0]  inj_c,
   // Resolved data bus as the controller sees it, flags, misuse seen
   output logic [15:0]      data_port_pins_in,
   output logic             any_error_flag,
   output logic             error_class_flag_low,
   output logic             error_class_flag_high,
   output logic             misuse
);
   // ****
   // Code matrix: distinct weight-3 columns, values are arbitrary
   // ****
   localparam logic [5:0] COL [16] = '{6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h19,
                                       6'h1A, 6'h1C, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C};
   logic [15:0] data_input_latch;
   logic [15:0] data_output_latch;
   logic [15:0] corrected;
   logic [15:0] last_r;
   logic [15:0] mem_d = 16'h0000;
   logic [5:0]  mem_c = 6'h00;
   logic [5:0]  check_input_latch;
   logic [5:0]  syn;
   logic        rd_hold_r = 1'b0;
   logic        misuse_r = 1'b0;
   assign misuse = misuse_r;
   function automatic logic [5:0] gen(input logic [15:0] d);
      gen = 6'h00;
      for (int i = 0; i < 16; i++) begin
         if (d[i]) gen ^= COL[i];
      end
   endfunction : gen
   always_latch if (data_in_latch_enable) data_input_latch = data_port_pins_in;
   always_latch if (check_syndrome_latch_enable) check_input_latch = mem_c;
   assign syn = check_input_latch ^ gen(data_input_latch);
   always_comb begin
      corrected = data_input_latch;
      for (int i = 0; i < 16; i++) begin
         if (mode_rw_bit && syn == COL[i]) corrected[i] = ~data_input_latch[i];
      end
   end
   always_latch if (!output_latch_enable_n) data_output_latch = corrected;
   assign any_error_flag = (syn != 6'h00);
   // Odd syndrome weight means a single error
   assign error_class_flag_high = ^syn;
   assign error_class_flag_low  = (syn != 6'h00) && (corrected != data_input_latch);
   always_comb begin
      // A released bus never keeps its last value
      data_port_pins_in = ~last_r;
      // Memory holds its data one cycle past its enable, so the data latch closes on steady data
      if (mem_read_en || rd_hold_r) data_port_pins_in = mem_d;
      if (!data_buffer_enable_lo_n) data_port_pins_in[7:0] = data_output_latch[7:0];
      if (!data_buffer_enable_hi_n) data_port_pins_in[15:8] = data_output_latch[15:8];
      data_port_pins_in = (data_port_pins_in & ~data_port_pins_oe) | (data_port_pins_out & data_port_pins_oe);
   end
   // ****
   // Memory array and misuse watch
   // ****
   always @(posedge core_clk) begin
      last_r <= data_port_pins_in;
      rd_hold_r <= mem_read_en;
      if (mem_write_en) begin
         mem_d <= data_port_pins_in;
         mem_c <= mode_rw_bit ? ~mem_c : gen(data_output_latch);
      end
      if (inj) begin
         mem_d <= mem_d ^ inj_d;
         mem_c <= mem_c ^ inj_c;
      end
      // Single device: the syndrome port stays unused, expansion needs a further device
      if (syndrome_output_enable_n | mode_select_bit1 | mode_select_bit0) misuse_r <= 1'b1;
      if (mem_read_en & ~mode_rw_bit) misuse_r <= 1'b1;
      if ((|data_port_pins_oe) & (mem_read_en | ~data_buffer_enable_lo_n | ~data_buffer_enable_hi_n)) misuse_r <= 1'b1;
   end
endmodule : ecm_dev_model

/* tb_ecm_ctrl.sv */
// Self-checking testbench of the ECC chip controller
`timescale 1ns/1ps
module tb_ecm_ctrl;
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] inj_d;
      logic [5:0]  inj_c;
      logic        scrub;
      logic [1:0]  cls;
   } ecm_row_s;
   // ****
   // Ordinary cases: stored word, injected fault, scrub, expected class
   // ****
   localparam ecm_row_s ROWS [7] = '{'{16'hA5C3, 16'h0000, 6'h00, 1'b0, 2'h0},
      '{16'h0000, 16'h0001, 6'h00, 1'b0, 2'h2}, '{16'hFFFF, 16'h8000, 6'h00, 1'b0, 2'h2},
      '{16'h1234, 16'h0000, 6'h20, 1'b0, 2'h1}, '{16'h5A5A, 16'h0003, 6'h00, 1'b0, 2'h3},
      '{16'h0F0F, 16'h0000, 6'h01, 1'b1, 2'h1}, '{16'hC3C3, 16'h0100, 6'h00, 1'b1, 2'h2}};
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic        inj = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [15:0] inj_d = 16'h0000;
   logic [5:0]  inj_c = 6'h00;
   logic [31:0] rdata;
   logic [31:0] got;
   logic        data_in_latch_enable, check_syndrome_latch_enable, output_latch_enable_n;
   logic        syndrome_output_enable_n, data_buffer_enable_lo_n, data_buffer_enable_hi_n;
   logic        mode_rw_bit, mode_select_bit1, mode_select_bit0, mem_read_en, mem_write_en;
   logic        any_error_flag, error_class_flag_low, error_class_flag_high, proc_wait, misuse;
   logic [15:0] data_port_pins_in, data_port_pins_out, data_port_pins_oe;
   int          fails = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          exp_cnt = 0;
   ecm_ctrl dut (
      .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .data_in_latch_enable(data_in_latch_enable),
      .check_syndrome_latch_enable(check_syndrome_latch_enable),
      .output_latch_enable_n(output_latch_enable_n), .syndrome_output_enable_n(syndrome_output_enable_n),
      .data_buffer_enable_lo_n(data_buffer_enable_lo_n), .data_buffer_enable_hi_n(data_buffer_enable_hi_n),
      .mode_rw_bit(mode_rw_bit), .mode_select_bit1(mode_select_bit1), .mode_select_bit0(mode_select_bit0),
      .any_error_flag(any_error_flag), .error_class_flag_low(error_class_flag_low),
      .error_class_flag_high(error_class_flag_high), .data_port_pins_in(data_port_pins_in),
      .data_port_pins_out(data_port_pins_out), .data_port_pins_oe(data_port_pins_oe),
      .mem_read_en(mem_read_en), .mem_write_en(mem_write_en), .proc_wait(proc_wait)
   );
   ecm_dev_model dev (
      .core_clk(core_clk), .inj(inj), .inj_d(inj_d), .inj_c(inj_c), .misuse(misuse),
      .data_in_latch_enable(data_in_latch_enable),
      .check_syndrome_latch_enable(check_syndrome_latch_enable),
      .output_latch_enable_n(output_latch_enable_n), .syndrome_output_enable_n(syndrome_output_enable_n),
      .data_buffer_enable_lo_n(data_buffer_enable_lo_n), .data_buffer_enable_hi_n(data_buffer_enable_hi_n),
      .mode_rw_bit(mode_rw_bit), .mode_select_bit1(mode_select_bit1), .mode_select_bit0(mode_select_bit0),
      .mem_read_en(mem_read_en), .mem_write_en(mem_write_en), .data_port_pins_out(data_port_pins_out),
      .data_port_pins_oe(data_port_pins_oe), .data_port_pins_in(data_port_pins_in),
      .any_error_flag(any_error_flag), .error_class_flag_low(error_class_flag_low),
      .error_class_flag_high(error_class_flag_high)
   );
   always #(ecm_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      @(negedge core_clk);
      got = rdata;
   endtask : rd
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Polls busy with a bound, leaves the last status word in got
   task automatic idle_wait;
      int n;
      n = 0;
      do begin
         rd(ecm_pkg::REG_STATUS);
         n++;
      end while (got[0] !== 1'b0 && n < 60);
      chk({31'h0, got[0]}, 32'h0);
   endtask : idle_wait
   task automatic op(input logic [31:0] ctrl, input logic [1:0] cls, input logic [15:0] d);
      wr(ecm_pkg::REG_CTRL, ctrl);
      idle_wait();
      chk({30'h0, got[3:2]}, {30'h0, cls});
      rd(ecm_pkg::REG_RDATA);
      if (cls != 2'h3) chk(got, {16'h0, d});
   endtask : op
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      foreach (ROWS[i]) begin
         wr(ecm_pkg::REG_WDATA, {16'h0000, ROWS[i].data});
         wr(ecm_pkg::REG_CTRL, 32'h0000_0001);
         idle_wait();
         @(posedge core_clk);
         inj <= 1'b1;
         inj_d <= ROWS[i].inj_d;
         inj_c <= ROWS[i].inj_c;
         @(posedge core_clk);
         inj <= 1'b0;
         if (ROWS[i].cls != 2'h0) exp_cnt++;
         op({29'h0, ROWS[i].scrub, 2'b10}, ROWS[i].cls, ROWS[i].data);
         // A scrubbed word must read back clean
         if (ROWS[i].scrub) begin
            rd(ecm_pkg::REG_CTRL);
            chk(got, 32'h0000_0004);
            op(32'h0000_0002, 2'h0, ROWS[i].data);
         end
      end
      rd(ecm_pkg::REG_ERRCNT);
      chk(got, 32'(exp_cnt));
      // ****
      // Awkward cases: refused writes while busy, reset while idle
      // ****
      wr(ecm_pkg::REG_WDATA, 32'h0000_1111);
      wr(ecm_pkg::REG_CTRL, 32'h0000_0003);
      @(negedge core_clk);
      chk({13'h0, mode_rw_bit, data_in_latch_enable, proc_wait, data_port_pins_oe}, {13'h0, 3'b011, 16'hFFFF});
      wr(ecm_pkg::REG_WDATA, 32'h0000_2222);
      idle_wait();
      op(32'h0000_0002, 2'h0, 16'h1111);
      rd(ecm_pkg::REG_WDATA);
      chk(got, 32'h0000_1111);
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      @(negedge core_clk);
      chk({26'h0, output_latch_enable_n, data_buffer_enable_lo_n, data_buffer_enable_hi_n,
           syndrome_output_enable_n, mode_rw_bit, proc_wait}, 32'h0000_0038);
      rd(ecm_pkg::REG_ERRCNT);
      chk(got, 32'h0000_0000);
      rd(8'h14);
      chk(got, 32'h0000_0000);
      chk({31'h0, misuse}, 32'h0);
      conclude();
   end
endmodule : tb_ecm_ctrl
